//--- rtl/hmw_mailbox.sv
/*
  Host mailbox and shared-memory window: command bytes both ways, a masked
  AND-OR interrupt from three cause flags, and a byte pointer into the shared RAM
  with auto-increment and fixed data ports.
  Assumes host strobes are synchronous one-cycle pulses, never read and write
  together, and the engine's event inputs are one-cycle pulses.
*/
`timescale 1ns/1ps
`default_nettype none
// Function
// - interrupt is OR over flags of flag AND its enable bit
// - a flag contributes only when its enable bit is 1
// - cause register reads raw flags, unmasked
// - force write 1 sets flag; 0 leaves it alone
// - engine consuming host command sets cause bit 0
// - serial link reset sets cause bit 1
// - engine writing device command byte sets cause bit 2
// - force register is write-only; bit 1 cannot be forced
// - bits 7 to 3 of enable, cause, force read zero
// - all flags are 0 after reset until an event or force
// - both command registers hold a full readable writable byte
// - 16 kbyte RAM shared by host window and engine
// - host RAM accesses are single bytes at byte addresses
// - pointer is a 16-bit absolute byte index; RAM takes bits 13 to 0 and auto-increment past 3fff gives 0000
// - fixed port accesses without changing the pointer
// - host may write any RAM location
// - writing 1 to a cause bit clears it; 0 leaves it
// - new host command byte write clears command-taken flag
// - any write to init trigger starts engine; it reads zero
// - pointer reachable as high byte and low byte registers
module hmw_mailbox (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // host byte bus
  input wire logic [hmw_pkg::HMW_ADDR_W-1:0] i_host_addr,
  input wire logic i_host_wr,
  input wire logic i_host_rd,
  input wire logic [7:0] i_host_wdata,
  output logic [7:0] o_host_rdata,
  output logic o_host_rvalid,
  output logic o_host_irq,
  // engine side
  input wire logic i_host_cmd_ack,
  input wire logic i_link_reset,
  input wire logic i_dev_cmd_wr,
  input wire logic [7:0] i_dev_cmd_data,
  output logic [7:0] o_host_command_byte,
  output logic o_engine_start,
  input wire logic [hmw_pkg::HMW_RAM_AW-1:0] i_eng_addr,
  input wire logic i_eng_we,
  input wire logic [7:0] i_eng_wdata,
  output logic [7:0] o_eng_rdata
);
  import hmw_pkg::*;

  // ==========================================================
  // address decode
  wire logic sel_en = (i_host_addr == HMW_OFF_IRQ_ENABLE_MASK);
  wire logic sel_cause = (i_host_addr == HMW_OFF_IRQ_CAUSE_FLAGS);
  wire logic sel_hcmd = (i_host_addr == HMW_OFF_HOST_COMMAND_BYTE);
  wire logic sel_dcmd = (i_host_addr == HMW_OFF_DEVICE_COMMAND_BYTE);
  wire logic sel_init = (i_host_addr == HMW_OFF_INIT_COMPLETE_TRIGGER);
  wire logic sel_force = (i_host_addr == HMW_OFF_IRQ_FORCE_FLAGS);
  wire logic sel_phi = (i_host_addr == HMW_OFF_MEMORY_POINTER_HIGH);
  wire logic sel_plo = (i_host_addr == HMW_OFF_MEMORY_POINTER_LOW);
  wire logic sel_inc = (i_host_addr == HMW_OFF_MEMORY_DATA_AUTOINC);
  wire logic sel_fix = (i_host_addr == HMW_OFF_MEMORY_DATA_FIXED);
  wire logic sel_ram = sel_inc | sel_fix;
  wire logic host_acc = i_host_wr | i_host_rd;

  // ==========================================================
  // registers
  logic [2:0] enable_ff;
  logic [2:0] cause_ff;
  logic [7:0] hcmd_ff;
  logic [7:0] dcmd_ff;
  logic [15:0] ptr_ff;
  logic start_ff;
  logic irq_ff;

  wire logic [2:0] ev_set = {i_dev_cmd_wr, i_link_reset, i_host_cmd_ack};
  // bit 1 stripped: link reset flag is not forceable
  wire logic [2:0] force_set = (i_host_wr && sel_force) ?
                               (i_host_wdata[2:0] & HMW_FORCE_MASK) : 3'h0;
  wire logic [2:0] w1c_clr = (i_host_wr && sel_cause) ? i_host_wdata[2:0] : 3'h0;
  wire logic [2:0] hcmd_clr = (i_host_wr && sel_hcmd) ? 3'h1 : 3'h0;
  // set beats clear so an engine event is never lost
  wire logic [2:0] nxt_cause = (cause_ff & ~(w1c_clr | hcmd_clr)) | ev_set | force_set;
  wire logic nxt_irq = |(nxt_cause & enable_ff);

  // ==========================================================
  // pointer
  wire logic [13:0] ptr_inc = (ptr_ff[13:0] == HMW_RAM_LAST) ? 14'h0000 :
                              ptr_ff[13:0] + 14'h0001;
  wire logic [15:0] nxt_ptr =
    (i_host_wr && sel_phi) ? {i_host_wdata, ptr_ff[7:0]} :
    (i_host_wr && sel_plo) ? {ptr_ff[15:8], i_host_wdata} :
    (host_acc && sel_inc) ? {2'b00, ptr_inc} :
    ptr_ff;

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cause_ff <= HMW_FLAGS_RST;
      irq_ff <= 1'b0;
    end else begin
      cause_ff <= nxt_cause;
      irq_ff <= nxt_irq;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      enable_ff <= HMW_FLAGS_RST;
      hcmd_ff <= HMW_BYTE_RST;
      start_ff <= 1'b0;
      ptr_ff <= HMW_PTR_RST;
    end else begin
      if (i_host_wr && sel_en) begin
        enable_ff <= i_host_wdata[2:0];
      end
      if (i_host_wr && sel_hcmd) begin
        hcmd_ff <= i_host_wdata;
      end
      if (i_host_wr && sel_init) begin
        start_ff <= 1'b1;
      end
      ptr_ff <= nxt_ptr;
    end
  end

  // engine write wins over a host write in the same cycle
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dcmd_ff <= HMW_BYTE_RST;
    end else if (i_dev_cmd_wr) begin
      dcmd_ff <= i_dev_cmd_data;
    end else if (i_host_wr && sel_dcmd) begin
      dcmd_ff <= i_host_wdata;
    end
  end

  // ==========================================================
  // shared RAM
  logic [7:0] ram_q;
  wire logic ram_we = i_host_wr && sel_ram;

  hmw_ram u_ram (
    .i_mclk(i_mclk),
    .i_a_addr(ptr_ff[13:0]),
    .i_a_we(ram_we),
    .i_a_wdata(i_host_wdata),
    .o_a_rdata(ram_q),
    .i_b_addr(i_eng_addr),
    .i_b_we(i_eng_we),
    .i_b_wdata(i_eng_wdata),
    .o_b_rdata(o_eng_rdata)
  );

  // ==========================================================
  // read path: two cycles so register and RAM reads share one latency
  wire logic [7:0] reg_rd =
    sel_en ? {5'h00, enable_ff} :
    sel_cause ? {5'h00, cause_ff} :
    sel_hcmd ? hcmd_ff :
    sel_dcmd ? dcmd_ff :
    sel_phi ? ptr_ff[15:8] :
    sel_plo ? ptr_ff[7:0] :
    8'h00;

  logic rd_p1_ff;
  logic ram_p1_ff;
  logic [7:0] reg_p1_ff;
  logic [7:0] rdata_ff;
  logic rvalid_ff;

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rd_p1_ff <= 1'b0;
      ram_p1_ff <= 1'b0;
      reg_p1_ff <= HMW_BYTE_RST;
      rdata_ff <= HMW_BYTE_RST;
      rvalid_ff <= 1'b0;
    end else begin
      rd_p1_ff <= i_host_rd && !i_host_wr;
      ram_p1_ff <= sel_ram;
      reg_p1_ff <= reg_rd;
      rvalid_ff <= rd_p1_ff;
      if (rd_p1_ff) begin
        rdata_ff <= ram_p1_ff ? ram_q : reg_p1_ff;
      end
    end
  end

  assign o_host_rdata = rdata_ff;
  assign o_host_rvalid = rvalid_ff;
  assign o_host_irq = irq_ff;
  assign o_host_command_byte = hcmd_ff;
  assign o_engine_start = start_ff;
endmodule
`default_nettype wire

//--- rtl/hmw_pkg.sv
/*
  Package for the host mailbox and shared-memory window: register offsets on the
  4-bit host address, cause/enable field positions, reset values and RAM sizing.
  Assumes a single 50 MHz system clock domain.
*/
`default_nettype none
package hmw_pkg;
  localparam int unsigned HMW_ADDR_W = 4;
  localparam int unsigned HMW_DATA_W = 8;
  localparam int unsigned HMW_PTR_W = 16;
  localparam int unsigned HMW_RAM_AW = 14;
  localparam int unsigned HMW_RAM_BYTES = 16384;

  // host register offsets
  localparam logic [3:0] HMW_OFF_IRQ_ENABLE_MASK = 4'h1;
  localparam logic [3:0] HMW_OFF_IRQ_CAUSE_FLAGS = 4'h2;
  localparam logic [3:0] HMW_OFF_HOST_COMMAND_BYTE = 4'h3;
  localparam logic [3:0] HMW_OFF_DEVICE_COMMAND_BYTE = 4'h4;
  localparam logic [3:0] HMW_OFF_INIT_COMPLETE_TRIGGER = 4'h5;
  localparam logic [3:0] HMW_OFF_IRQ_FORCE_FLAGS = 4'h6;
  localparam logic [3:0] HMW_OFF_MEMORY_POINTER_HIGH = 4'hc;
  localparam logic [3:0] HMW_OFF_MEMORY_POINTER_LOW = 4'hd;
  localparam logic [3:0] HMW_OFF_MEMORY_DATA_AUTOINC = 4'he;
  localparam logic [3:0] HMW_OFF_MEMORY_DATA_FIXED = 4'hf;

  // cause / enable / force bit positions
  localparam int unsigned HMW_BIT_HOST_CMD_TAKEN = 0;
  localparam int unsigned HMW_BIT_SERIAL_LINK_RESET = 1;
  localparam int unsigned HMW_BIT_DEVICE_CMD_PENDING = 2;
  localparam int unsigned HMW_FLAG_W = 3;
  localparam logic [2:0] HMW_FORCE_MASK = 3'h5;

  localparam logic [2:0] HMW_FLAGS_RST = 3'h0;
  localparam logic [7:0] HMW_BYTE_RST = 8'h00;
  localparam logic [15:0] HMW_PTR_RST = 16'h0000;
  localparam logic [13:0] HMW_RAM_LAST = 14'h3fff;
endpackage
`default_nettype wire

//--- rtl/hmw_ram.sv
/*
  Shared byte RAM with two ports, one for the host window and one for the engine.
  Each port has registered read data, one cycle after the address is taken.
  Assumes the two users never write the same byte in the same cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module hmw_ram (
  input wire logic i_mclk,
  input wire logic [hmw_pkg::HMW_RAM_AW-1:0] i_a_addr,
  input wire logic i_a_we,
  input wire logic [7:0] i_a_wdata,
  output logic [7:0] o_a_rdata,
  input wire logic [hmw_pkg::HMW_RAM_AW-1:0] i_b_addr,
  input wire logic i_b_we,
  input wire logic [7:0] i_b_wdata,
  output logic [7:0] o_b_rdata
);
  import hmw_pkg::*;

  logic [7:0] mem_ff [HMW_RAM_BYTES];

  // no reset on the array: contents are loaded by the host after power-on
  always_ff @(posedge i_mclk) begin
    if (i_a_we) begin
      mem_ff[i_a_addr] <= i_a_wdata;
    end
    if (i_b_we) begin
      mem_ff[i_b_addr] <= i_b_wdata;
    end
    o_a_rdata <= mem_ff[i_a_addr];
    o_b_rdata <= mem_ff[i_b_addr];
  end
endmodule
`default_nettype wire

//--- testbench/hmw_monitor.sv
/* checker for hmw_mailbox: read latency, reserved bits, irq and start.
   bound to the top module ports from the bench. */
`timescale 1ns/1ps
`default_nettype none
module hmw_monitor (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic [3:0] i_host_addr,
  input wire logic i_host_wr,
  input wire logic i_host_rd,
  input wire logic i_host_cmd_ack,
  input wire logic i_link_reset,
  input wire logic i_dev_cmd_wr,
  input wire logic [7:0] o_host_rdata,
  input wire logic o_host_rvalid,
  input wire logic o_host_irq,
  input wire logic o_engine_start
);
  // ==========
  // checks
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  wire logic rd_go = i_host_rd && !i_host_wr;
  // any cause of an irq change, window kept at three cycles
  wire logic ev = i_host_cmd_ack | i_link_reset | i_dev_cmd_wr | i_host_wr;
  a_rd_lat: assert property (rd_go |-> ##2 o_host_rvalid) else $error("late rvalid");
  a_rv_src: assert property (o_host_rvalid |-> $past(rd_go, 2)) else $error("stray rvalid");
  a_wr_quiet: assert property (i_host_wr |-> ##2 !o_host_rvalid) else $error("rvalid on write");
  a_start_set: assert property (i_host_wr && i_host_addr == 4'h5 |=> o_engine_start)
    else $error("no start");
  a_start_held: assert property (o_engine_start |=> o_engine_start) else $error("start lost");
  a_rsv_bits: assert property (o_host_rvalid && $past(i_host_addr, 2) inside {4'h1, 4'h2, 4'h6}
    |-> o_host_rdata[7:3] == 5'h00) else $error("reserved bits set");
  a_init_zero: assert property (o_host_rvalid && $past(i_host_addr, 2) == 4'h5
    |-> o_host_rdata == 8'h00) else $error("init reg not zero");
  a_force_zero: assert property (o_host_rvalid && $past(i_host_addr, 2) == 4'h6
    |-> o_host_rdata == 8'h00) else $error("force reg readable");
  a_irq_rise: assert property ($rose(o_host_irq) |-> $past(ev) || $past(ev, 2) || $past(ev, 3))
    else $error("irq without cause");
  a_irq_fall: assert property ($fell(o_host_irq) |-> $past(i_host_wr) || $past(i_host_wr, 2)
    || $past(i_host_wr, 3)) else $error("irq dropped alone");
  c_irq: cover property ($rose(o_host_irq));
  c_next: cover property (o_host_rvalid && $past(i_host_addr, 2) == 4'he);
  c_start: cover property ($rose(o_engine_start));
endmodule
`default_nettype wire

//--- testbench/hmw_host_model.sv
/* host microcontroller model: byte bus write and read cycles.
   assumes the mailbox shares its clock. */
`timescale 1ns/1ps
`default_nettype none
module hmw_host_model (
  input wire logic i_mclk,
  input wire logic [7:0] i_rdata,
  input wire logic i_rvalid,
  output logic [3:0] o_addr,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_wdata
);
  // ==========
  // bus cycles, one byte each
  initial begin
    o_addr = 4'h0;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 8'h00;
  end
  // released lines show the inverse so stale values never match
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_mclk) #1;
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(posedge i_mclk) #1;
    o_wr = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    int n;
    @(posedge i_mclk) #1;
    o_addr = a;
    o_rd = 1'b1;
    @(posedge i_mclk) #1;
    o_rd = 1'b0;
    o_addr = ~a;
    for (n = 0; n < 4 && i_rvalid !== 1'b1; n++) @(posedge i_mclk) #1;
    d = (i_rvalid === 1'b1) ? i_rdata : 8'hxx;
  endtask
endmodule
`default_nettype wire

//--- testbench/hmw_mailbox_test.sv
/* bench for hmw_mailbox: host model on the byte bus, engine pulses
   and engine ram port driven here. */
`timescale 1ns/1ps
`default_nettype none
module hmw_mailbox_test;
  logic clk, rst_b, ack, lrst, dwr, ewe, hw, hr, rv, irq, st;
  logic [7:0] dcd, ewd, hrd, erd, hcb, hwd, r, d;
  logic [7:0] v [4];
  logic [3:0] ha;
  logic [13:0] ea;
  logic [15:0] p;
  int fail_count, n_compared, i;
  hmw_mailbox i_dut (.i_mclk(clk), .i_rst_b(rst_b), .i_host_addr(ha), .i_host_wr(hw),
    .i_host_rd(hr), .i_host_wdata(hwd), .o_host_rdata(hrd), .o_host_rvalid(rv),
    .o_host_irq(irq), .i_host_cmd_ack(ack), .i_link_reset(lrst), .i_dev_cmd_wr(dwr),
    .i_dev_cmd_data(dcd), .o_host_command_byte(hcb), .o_engine_start(st), .i_eng_addr(ea),
    .i_eng_we(ewe), .i_eng_wdata(ewd), .o_eng_rdata(erd));
  hmw_host_model i_host (.i_mclk(clk), .i_rdata(hrd), .i_rvalid(rv), .o_addr(ha),
    .o_wr(hw), .o_rd(hr), .o_wdata(hwd));
  // ==========
  // helpers
  function automatic logic [15:0] nxt_p(input logic [15:0] q);
    return {2'b00, q[13:0] + 14'h0001};
  endfunction
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(input string n, input logic [3:0] a, input logic [7:0] e);
    i_host.rd(a, d);
    chk(n, e, d);
  endtask
  task automatic pulse(ref logic s);
    @(posedge clk) #1;
    s = 1'b1;
    @(posedge clk) #1;
    s = 1'b0;
    repeat (2) @(posedge clk) #1;
  endtask
  task final_report;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    final_report;
  end
  // ==========
  // scenarios
  initial begin
    {rst_b, ack, lrst, dwr, ewe, dcd, ewd, ea} = '0;
    void'($urandom(6));
    repeat (5) @(posedge clk);
    #1 rst_b = 1'b1;
    rchk("cause", 4'h2, 8'h00);
    rchk("ptrlo", 4'hd, 8'h00);
    r = 8'($urandom);
    i_host.wr(4'h3, r);
    chk("hcmd", r, hcb);
    rchk("hcmd_rd", 4'h3, r);
    r = 8'($urandom);
    i_host.wr(4'h4, r);
    rchk("dcmd", 4'h4, r);
    p = 16'h3ffe;
    i_host.wr(4'hc, p[15:8]);
    i_host.wr(4'hd, p[7:0]);
    for (i = 0; i < 4; i++) begin
      v[i] = 8'($urandom);
      i_host.wr(4'he, v[i]);
      p = nxt_p(p);
    end
    rchk("ptrhi", 4'hc, p[15:8]);
    rchk("ptrlo", 4'hd, p[7:0]);
    i_host.wr(4'hd, 8'hfe);
    i_host.wr(4'hc, 8'h3f);
    for (i = 0; i < 4; i++) rchk("next", 4'he, v[i]);
    i_host.wr(4'hf, r);
    rchk("cur", 4'hf, r);
    rchk("ptr_kept", 4'hd, p[7:0]);
    ea = 14'h3fff;
    @(posedge clk) #1;
    chk("eng_rd", v[1], erd);
    ea = 14'($urandom);
    ewd = 8'($urandom);
    ewe = 1'b1;
    @(posedge clk) #1;
    ewe = 1'b0;
    i_host.wr(4'hc, {2'b00, ea[13:8]});
    i_host.wr(4'hd, ea[7:0]);
    rchk("eng_wr", 4'hf, ewd);
    i_host.wr(4'h1, 8'hff);
    rchk("en", 4'h1, 8'h07);
    pulse(ack);
    chk("irq_ack", 8'h01, {7'h00, irq});
    rchk("c_ack", 4'h2, 8'h01);
    i_host.wr(4'h2, 8'h00);
    rchk("c_w0", 4'h2, 8'h01);
    i_host.wr(4'h2, 8'h01);
    rchk("c_w1", 4'h2, 8'h00);
    chk("irq_clr", 8'h00, {7'h00, irq});
    i_host.wr(4'h1, 8'h00);
    pulse(lrst);
    chk("irq_mask", 8'h00, {7'h00, irq});
    rchk("c_lrst", 4'h2, 8'h02);
    dcd = r ^ 8'h5a;
    pulse(dwr);
    rchk("c_dev", 4'h2, 8'h06);
    rchk("dcmd_eng", 4'h4, dcd);
    i_host.wr(4'h2, 8'hff);
    // host forces bits 0 and 1; only command-taken sets, the unforceable link-reset bit 1 must stay clear
    i_host.wr(4'h6, 8'h03);
    rchk("c_force", 4'h2, 8'h01);
    rchk("force_rd", 4'h6, 8'h00);
    i_host.wr(4'h3, r);
    rchk("c_newcmd", 4'h2, 8'h00);
    pulse(dwr);
    rchk("c_dev2", 4'h2, 8'h04);
    i_host.wr(4'h1, 8'h04);
    repeat (2) @(posedge clk) #1;
    chk("irq_en", 8'h01, {7'h00, irq});
    i_host.wr(4'h5, r);
    chk("start", 8'h01, {7'h00, st});
    rchk("init_rd", 4'h5, 8'h00);
    rchk("rsv", 4'h9, 8'h00);
    final_report;
  end
endmodule
bind hmw_mailbox hmw_monitor i_mon (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
  .i_host_addr(i_host_addr), .i_host_wr(i_host_wr), .i_host_rd(i_host_rd),
  .i_host_cmd_ack(i_host_cmd_ack), .i_link_reset(i_link_reset), .i_dev_cmd_wr(i_dev_cmd_wr),
  .o_host_rdata(o_host_rdata), .o_host_rvalid(o_host_rvalid), .o_host_irq(o_host_irq),
  .o_engine_start(o_engine_start));
`default_nettype wire
